// ==== rtl/pps_sequencer.sv ====
`include "pps_consts.svh"

module pps_sequencer (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Program load port
  input wire pps_pkg::pps_load_t i_load,
  // Software control
  input wire logic i_sw_start,
  input wire logic i_sw_stop,
  // External pins
  input wire logic i_external_trigger_input,
  input wire logic i_external_halt_input,
  // Outputs
  output logic [`PPS_OUT_W-1:0] o_outputs,
  output logic o_analog_en,
  output logic o_running,
  output logic o_waiting,
  output logic [`PPS_ADDR_W-1:0] o_pc
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic trig_fall;
  logic halt_level;

  pps_sync u_trig_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_pin(i_external_trigger_input),
    .o_level(),
    .o_fall(trig_fall)
  );

  pps_sync u_halt_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_pin(i_external_halt_input),
    .o_level(halt_level),
    .o_fall()
  );

  // ----------------------------------------
  // Program memory
  // ----------------------------------------
  pps_pkg::pps_instr_t prog_mem [`PPS_MEM_DEPTH];
  pps_pkg::pps_instr_t cur;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_ce && i_load.wr)
      prog_mem[i_load.addr] <= i_load.word;
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    PPS_IDLE,
    PPS_FETCH,
    PPS_EXEC,
    PPS_WAIT_TRIG,
    PPS_WAIT_DLY
  } pps_state_t;

  pps_state_t state_reg;
  logic [`PPS_ADDR_W-1:0] pc_reg;
  logic [`PPS_ADDR_W-1:0] pc_next;
  logic [`PPS_DLY_W-1:0] cnt_reg;
  logic [`PPS_DATA_W-1:0] rep_reg;
  logic [`PPS_OUT_W-1:0] out_reg;
  logic analog_reg;
  logic start_ev;
  logic dly_done;
  logic [`PPS_DATA_W-1:0] loop_top;
  logic [`PPS_DATA_W-1:0] ret_top;
  logic [`PPS_ADDR_W-1:0] seq_addr;
  logic [`PPS_DLY_W-1:0] exec_cnt;

  // Count totals delay plus the fixed overhead: one fetch cycle plus two here.
  assign exec_cnt = prog_mem[pc_reg].delay + `PPS_FIXED_OVH - 32'h0000_0001;
  assign cur = prog_mem[pc_reg];
  assign seq_addr = pc_reg + 1'b1;
  assign start_ev = i_sw_start | trig_fall;
  assign dly_done = (cnt_reg == 32'h0000_0001);

  // Loop counter stack and return address stack.
  logic loop_push;
  logic loop_pop;
  logic loop_dec;
  logic call_push;
  logic call_pop;
  logic stk_clear;

  always_comb
  begin
    loop_push = 1'b0;
    loop_pop = 1'b0;
    loop_dec = 1'b0;
    call_push = 1'b0;
    call_pop = 1'b0;
    if (state_reg == PPS_EXEC && dly_done && rep_reg <= 20'h00001)
    begin
      case (cur.opcode)
        pps_pkg::PPS_OP_LOOP: loop_push = 1'b1;
        pps_pkg::PPS_OP_END_LOOP:
        begin
          loop_pop = (loop_top <= `PPS_LOOP_MIN);
          loop_dec = (loop_top > `PPS_LOOP_MIN);
        end
        pps_pkg::PPS_OP_SUBROUTINE_CALL: call_push = 1'b1;
        pps_pkg::PPS_OP_RETURN: call_pop = 1'b1;
        default: ;
      endcase
    end
  end

  assign stk_clear = (state_reg == PPS_IDLE);

  pps_stack #(.WIDTH(`PPS_DATA_W)) u_loop_stack (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_clear(stk_clear),
    .i_push(loop_push),
    .i_push_data(cur.data),
    .i_pop(loop_pop),
    .i_top_we(loop_dec),
    .i_top_data(loop_top - 20'h00001),
    .o_top(loop_top)
  );

  pps_stack #(.WIDTH(`PPS_DATA_W)) u_call_stack (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_clear(stk_clear),
    .i_push(call_push),
    .i_push_data({{(`PPS_DATA_W-`PPS_ADDR_W){1'b0}}, seq_addr}),
    .i_pop(call_pop),
    .i_top_we(1'b0),
    .i_top_data('0),
    .o_top(ret_top)
  );

  // ----------------------------------------
  // Next address
  // ----------------------------------------
  always_comb
  begin
    pc_next = seq_addr;
    case (cur.opcode)
      pps_pkg::PPS_OP_END_LOOP:
        if (loop_top > `PPS_LOOP_MIN)
          pc_next = cur.data[`PPS_ADDR_W-1:0];
      pps_pkg::PPS_OP_SUBROUTINE_CALL: pc_next = cur.data[`PPS_ADDR_W-1:0];
      pps_pkg::PPS_OP_RETURN: pc_next = ret_top[`PPS_ADDR_W-1:0];
      pps_pkg::PPS_OP_JUMP: pc_next = cur.data[`PPS_ADDR_W-1:0];
      default: pc_next = seq_addr;
    endcase
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  // External halt has priority over every other event, including a start.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      state_reg <= PPS_IDLE;
      pc_reg <= '0;
      cnt_reg <= '0;
      rep_reg <= '0;
    end
    else if (i_ce)
    begin
      if (!halt_level || i_sw_stop)
      begin
        state_reg <= PPS_IDLE;
        pc_reg <= '0;
      end
      else
      begin
        case (state_reg)
          PPS_IDLE:
            if (start_ev)
            begin
              pc_reg <= '0;
              state_reg <= PPS_FETCH;
            end
          PPS_FETCH:
          begin
            cnt_reg <= exec_cnt;
            rep_reg <= (cur.opcode == pps_pkg::PPS_OP_LONG_DELAY) ? cur.data : 20'h00001;
            if (cur.opcode == pps_pkg::PPS_OP_STOP)
              state_reg <= PPS_IDLE;
            else if (cur.opcode == pps_pkg::PPS_OP_WAIT)
              state_reg <= PPS_WAIT_TRIG;
            else
              state_reg <= PPS_EXEC;
          end
          PPS_EXEC:
            if (!dly_done)
              cnt_reg <= cnt_reg - 32'h0000_0001;
            else if (rep_reg > 20'h00001)
            begin
              rep_reg <= rep_reg - 20'h00001;
              cnt_reg <= cur.delay;
            end
            else
            begin
              pc_reg <= pc_next;
              state_reg <= PPS_FETCH;
            end
          PPS_WAIT_TRIG:
            if (start_ev)
            begin
              cnt_reg <= cur.delay + `PPS_WAIT_EXTRA;
              state_reg <= PPS_WAIT_DLY;
            end
          PPS_WAIT_DLY:
            if (!dly_done)
              cnt_reg <= cnt_reg - 32'h0000_0001;
            else
            begin
              pc_reg <= seq_addr;
              state_reg <= PPS_FETCH;
            end
          default: state_reg <= PPS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // A stop leaves the digital pattern of the previous instruction on the lines.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      out_reg <= '0;
    else if (i_ce && halt_level && !i_sw_stop && state_reg == PPS_FETCH
             && cur.opcode != pps_pkg::PPS_OP_STOP)
      out_reg <= cur.pattern;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      analog_reg <= 1'b0;
    else if (i_ce)
      analog_reg <= halt_level && !i_sw_stop && state_reg != PPS_IDLE
                    && !(state_reg == PPS_FETCH && cur.opcode == pps_pkg::PPS_OP_STOP);
  end

  assign o_outputs = out_reg;
  assign o_analog_en = analog_reg;
  assign o_running = (state_reg != PPS_IDLE);
  assign o_waiting = (state_reg == PPS_WAIT_TRIG);
  assign o_pc = pc_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_fetch_continue;
    state_reg == PPS_FETCH && cur.opcode == pps_pkg::PPS_OP_CONTINUE && halt_level && !i_sw_stop && i_ce;
  endsequence

  chk_stop_goes_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_FETCH && cur.opcode == pps_pkg::PPS_OP_STOP)
      |=> (state_reg == PPS_IDLE && $stable(out_reg)))
    else $error("stop did not halt with outputs held");

  chk_halt_resets_pc: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && !halt_level) |=> (state_reg == PPS_IDLE && pc_reg == '0))
    else $error("external halt did not reset sequencer");

  chk_pattern_applied: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (s_fetch_continue) |=> (o_outputs == $past(cur.pattern)))
    else $error("pattern not applied at instruction start");

  chk_jump_target: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_EXEC && dly_done && rep_reg <= 20'h00001
     && cur.opcode == pps_pkg::PPS_OP_JUMP) |=> (pc_reg == $past(cur.data[`PPS_ADDR_W-1:0])))
    else $error("jump went to wrong address");

  chk_continue_next: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_EXEC && dly_done && rep_reg <= 20'h00001
     && cur.opcode == pps_pkg::PPS_OP_CONTINUE) |=> (pc_reg == $past(pc_reg) + 1'b1))
    else $error("continue did not advance");

  chk_fetch_count: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (s_fetch_continue) |=> (cnt_reg == $past(cur.delay) + 32'h0000_0002))
    else $error("delay count overhead wrong");

  chk_wait_release: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_WAIT_TRIG && start_ev)
      |=> (state_reg == PPS_WAIT_DLY && cnt_reg == $past(cur.delay) + 32'h0000_0006))
    else $error("wait release latency wrong");

  chk_wait_holds: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_WAIT_TRIG && !start_ev)
      |=> (state_reg == PPS_WAIT_TRIG && $stable(pc_reg)))
    else $error("wait left without trigger");

  chk_idle_start: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_ce && halt_level && !i_sw_stop && state_reg == PPS_IDLE && trig_fall)
      |=> (state_reg == PPS_FETCH && pc_reg == '0))
    else $error("trigger did not start from the top");

endmodule : pps_sequencer

// ==== rtl/pps_consts.svh ====
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define PPS_WORD_W 80
`define PPS_OUT_W 24
`define PPS_DATA_W 20
`define PPS_OPC_W 4
`define PPS_DLY_W 32
`define PPS_OUT_MSB 79
`define PPS_OUT_LSB 56
`define PPS_DATA_MSB 55
`define PPS_DATA_LSB 36
`define PPS_OPC_MSB 35
`define PPS_OPC_LSB 32
`define PPS_DLY_MSB 31
`define PPS_DLY_LSB 0

// ----------------------------------------
// Program memory and stacks
// ----------------------------------------
`define PPS_ADDR_W 9
`define PPS_MEM_DEPTH 512
`define PPS_STACK_DEPTH 8
`define PPS_SP_W 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PPS_FIXED_OVH 32'h0000_0003
`define PPS_WAIT_EXTRA 32'h0000_0006
`define PPS_LOOP_MIN 20'h00001
`define PPS_LONG_MIN 20'h00002

`endif

// ==== rtl/pps_pkg.sv ====
`include "pps_consts.svh"

package pps_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [`PPS_OPC_W-1:0] {
    PPS_OP_CONTINUE = 4'h0,
    PPS_OP_STOP = 4'h1,
    PPS_OP_LOOP = 4'h2,
    PPS_OP_END_LOOP = 4'h3,
    PPS_OP_SUBROUTINE_CALL = 4'h4,
    PPS_OP_RETURN = 4'h5,
    PPS_OP_JUMP = 4'h6,
    PPS_OP_LONG_DELAY = 4'h7,
    PPS_OP_WAIT = 4'h8
  } pps_opcode_t;

  typedef struct packed {
    logic [`PPS_OUT_W-1:0] pattern;
    logic [`PPS_DATA_W-1:0] data;
    logic [`PPS_OPC_W-1:0] opcode;
    logic [`PPS_DLY_W-1:0] delay;
  } pps_instr_t;

  typedef struct packed {
    logic wr;
    logic [`PPS_ADDR_W-1:0] addr;
    pps_instr_t word;
  } pps_load_t;

endpackage : pps_pkg

// ==== rtl/pps_sync.sv ====
module pps_sync (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Pin side
  input wire logic i_pin,
  // Synchronised level and falling edge
  output logic o_level,
  output logic o_fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Pins idle high, so reset values are high to avoid a false edge.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_fall = last_reg & ~sync_reg;

endmodule : pps_sync

// ==== rtl/pps_stack.sv ====
`include "pps_consts.svh"

module pps_stack #(
  parameter int WIDTH = 20
) (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_clear,
  // Operations
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_push_data,
  input wire logic i_pop,
  input wire logic i_top_we,
  input wire logic [WIDTH-1:0] i_top_data,
  // Top of stack
  output logic [WIDTH-1:0] o_top
);

  logic [WIDTH-1:0] mem [`PPS_STACK_DEPTH];
  logic [`PPS_SP_W-1:0] sp_reg;

  // Overflow wraps; nesting deeper than the stack corrupts the oldest entry.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn || (i_ce && i_clear))
      sp_reg <= '0;
    else if (i_ce && i_push)
      sp_reg <= sp_reg + 1'b1;
    else if (i_ce && i_pop)
      sp_reg <= sp_reg - 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_ce && i_push)
      mem[sp_reg] <= i_push_data;
    else if (i_ce && i_top_we)
      mem[sp_reg - 1'b1] <= i_top_data;
  end

  assign o_top = mem[sp_reg - 1'b1];

endmodule : pps_stack

// ==== tb/pps_host_model.sv ====
`include "pps_consts.svh"

module pps_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Toward the sequencer
  output pps_pkg::pps_load_t o_load,
  output logic o_trigger,
  output logic o_halt_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Test program
  // ----------------------------------------
  // Every delay is 2, the smallest count a loader may give, so each plain step takes 5 cycles.
  logic [`PPS_WORD_W-1:0] rom [12];

  initial
  begin
    rom[0] = {24'h000001, 20'h00000, 4'h0, 32'h0000_0002};
    rom[1] = {24'h000002, 20'h00008, 4'h4, 32'h0000_0002};
    rom[2] = {24'h000003, 20'h00002, 4'h2, 32'h0000_0002};
    rom[3] = {24'h000004, 20'hfffff, 4'h0, 32'h0000_0002};
    rom[4] = {24'h000005, 20'h00003, 4'h3, 32'h0000_0002};
    rom[5] = {24'h000006, 20'h00003, 4'h7, 32'h0000_0002};
    rom[6] = {24'h000007, 20'h0000a, 4'h6, 32'h0000_0002};
    rom[7] = {24'h000ff0, 20'h00000, 4'h1, 32'h0000_0002};
    rom[8] = {24'h000009, 20'h00000, 4'h0, 32'h0000_0002};
    rom[9] = {24'h00000a, 20'hfffff, 4'h5, 32'h0000_0002};
    rom[10] = {24'h00000b, 20'hfffff, 4'h8, 32'h0000_0002};
    rom[11] = {24'h00000c, 20'hfffff, 4'h1, 32'h0000_0002};
    o_load = '0;
    o_trigger = 1'b1;
    o_halt_n = 1'b1;
  end

  // ----------------------------------------
  // Loader and pins
  // ----------------------------------------
  task automatic load_all();
    for (int i = 0; i < 12; i++)
    begin
      @(negedge i_clk_sys);
      o_load = {1'b1, 9'(i), rom[i]};
    end
    // Idle lines show the inverse of the last word, so a stale capture cannot look right.
    @(negedge i_clk_sys);
    o_load.wr = 1'b0;
    o_load.addr = ~o_load.addr;
    o_load.word = ~o_load.word;
  endtask : load_all

  // Both pins idle high, as their pull-ups leave them.
  task automatic set_pins(input logic trig, input logic halt_n);
    @(negedge i_clk_sys);
    o_trigger = trig;
    o_halt_n = halt_n;
  endtask : set_pins
endmodule : pps_host_model

// ==== tb/pulse_program_sequencer_bench.sv ====
`include "pps_consts.svh"

module pulse_program_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end

  typedef struct packed {
    logic [8:0] pc;
    logic [23:0] pat;
    logic [7:0] dur;
  } pps_row_t;

  // ----------------------------------------
  // Expected trace: address, its pattern, cycles until the next fetch
  // ----------------------------------------
  localparam pps_row_t ROWS [12] = '{
    '{9'h000, 24'h000001, 8'h06}, '{9'h001, 24'h000002, 8'h05}, '{9'h008, 24'h000009, 8'h05},
    '{9'h009, 24'h00000a, 8'h05}, '{9'h002, 24'h000003, 8'h05}, '{9'h003, 24'h000004, 8'h05},
    '{9'h004, 24'h000005, 8'h05}, '{9'h003, 24'h000004, 8'h05}, '{9'h004, 24'h000005, 8'h05},
    '{9'h005, 24'h000006, 8'h09}, '{9'h006, 24'h000007, 8'h05}, '{9'h00a, 24'h00000b, 8'h00}};

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sw_start = 1'b0;
  logic sw_stop = 1'b0;
  logic ce = 1'b1;
  logic trigger;
  logic halt_n;
  pps_pkg::pps_load_t load;
  logic [`PPS_OUT_W-1:0] outputs;
  logic analog_en;
  logic running;
  logic waiting;
  logic [`PPS_ADDR_W-1:0] pc;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int prev;

  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  pps_host_model pps_host_model_i (.i_clk_sys(clk_sys), .o_load(load), .o_trigger(trigger), .o_halt_n(halt_n));

  pps_sequencer pps_sequencer_i (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_ce(ce), .i_load(load),
    .i_sw_start(sw_start), .i_sw_stop(sw_stop),
    .i_external_trigger_input(trigger), .i_external_halt_input(halt_n),
    .o_outputs(outputs), .o_analog_en(analog_en), .o_running(running), .o_waiting(waiting), .o_pc(pc));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // A hang would otherwise run forever; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic wait_pc(input logic [8:0] target);
    int n;
    n = 0;
    while (pc !== target && n < 60)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_pc

  task automatic pulse(input int which);
    @(negedge clk_sys);
    if (which == 0)
      sw_start = 1'b1;
    else
      sw_stop = 1'b1;
    prev = cyc;
    @(negedge clk_sys);
    sw_start = 1'b0;
    sw_stop = 1'b0;
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(negedge clk_sys);
    `CHK("reset pc", 9'h000, pc)
    `CHK("reset outputs", 24'h000000, outputs)
    `CHK("reset running", 1'b0, running)
    resetn = 1'b1;
    pps_host_model_i.load_all();
    pulse(0);
    for (int i = 1; i < 12; i++)
    begin
      wait_pc(ROWS[i].pc);
      `CHK("pc", ROWS[i].pc, pc)
      `CHK("cycles", ROWS[i - 1].dur, 8'(cyc - prev))
      `CHK("pattern", ROWS[i - 1].pat, outputs)
      prev = cyc;
    end
    repeat (20) @(negedge clk_sys);
    `CHK("wait pc", 9'h00a, pc)
    `CHK("waiting", 1'b1, waiting)
    pps_host_model_i.set_pins(1'b0, 1'b1);
    prev = cyc;
    wait_pc(9'h00b);
    // Three cycles of pin synchronisation come before the delay plus six.
    `CHK("wait latency", 32'h0000_000b, cyc - prev)
    pps_host_model_i.set_pins(1'b1, 1'b1);
    repeat (6) @(negedge clk_sys);
    `CHK("stop running", 1'b0, running)
    `CHK("stop analog", 1'b0, analog_en)
    `CHK("stop outputs held", 24'h00000b, outputs)
    pps_host_model_i.set_pins(1'b0, 1'b1);
    wait_pc(9'h001);
    `CHK("restart pc", 9'h001, pc)
    `CHK("restart analog", 1'b1, analog_en)
    pps_host_model_i.set_pins(1'b1, 1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK("halt running", 1'b0, running)
    `CHK("halt pc", 9'h000, pc)
    pps_host_model_i.set_pins(1'b1, 1'b1);
    // The halt synchroniser needs two edges before a start can be taken.
    repeat (3) @(negedge clk_sys);
    pulse(0);
    `CHK("start running", 1'b1, running)
    // With the clock enable low the first fetch must not move on.
    ce = 1'b0;
    repeat (8) @(negedge clk_sys);
    `CHK("frozen pc", 9'h000, pc)
    `CHK("frozen running", 1'b1, running)
    ce = 1'b1;
    pulse(1);
    @(negedge clk_sys);
    `CHK("sw stop running", 1'b0, running)
    `CHK("sw stop pc", 9'h000, pc)
    pulse(0);
    wait_pc(9'h001);
    resetn = 1'b0;
    repeat (6) @(negedge clk_sys);
    `CHK("mid reset pc", 9'h000, pc)
    `CHK("mid reset outputs", 24'h000000, outputs)
    `CHK("mid reset running", 1'b0, running)
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("after reset running", 1'b0, running)
    `CHK("after reset outputs", 24'h000000, outputs)
    summarize();
  end
endmodule : pulse_program_sequencer_bench
